/* File: src/sdac_consts.vh */
`ifndef SDAC_CONSTS_VH
`define SDAC_CONSTS_VH

// Data word layout
`define SDAC_DATA_W        16
`define SDAC_CODE_W        12
`define SDAC_SEL_BIT       15
`define SDAC_FAIL_BIT      14
`define SDAC_BUS2_BIT      13
`define SDAC_BUS1_BIT      12
`define SDAC_ROUTE_BIT     11
`define SDAC_TSEL_BIT      10
`define SDAC_START_BIT     9
`define SDAC_FIELD_BIT     8

// Channel organisation
`define SDAC_CH_N          16
`define SDAC_CH_W          4
`define SDAC_GROUP_N       4

// Word address (A15..A1) and compared fields
`define SDAC_ADDR_W        15
`define SDAC_HI_MSB        14
`define SDAC_HI_LSB        6
`define SDAC_LO_MSB        5
`define SDAC_LO_LSB        4
`define SDAC_CH_MSB        3
`define SDAC_CH_LSB        0
`define SDAC_HI_W          9
`define SDAC_LO_W          2

// Factory switch positions (1 = open), base 0xFF0060
`define SDAC_HI_SW_FACTORY 9'h000
`define SDAC_LO_SW_FACTORY 2'h3
`define SDAC_BASE_FACTORY  24'hFF_0060

// Reset values
`define SDAC_CTRL_RST      7'h00
`define SDAC_CODE_RST      12'h000
`define SDAC_TSEL_RST      4'h0

// Documented control words
`define SDAC_CW_IMM_FIELD  16'hC100
`define SDAC_CW_IMM_BUS2   16'hEC00
`define SDAC_CW_IMM_BUS1   16'hDC00
`define SDAC_CW_IMM_B2FLD  16'hED00
`define SDAC_CW_DLY_FIELD  16'hC300
`define SDAC_CW_DLY_BUS2   16'hEE00
`define SDAC_CW_DLY_BUS1   16'hDE00
`define SDAC_CW_DLY_B2FLD  16'hEF00

`endif

/* File: src/sdac_board_decode.v */
`timescale 1ns/100ps
`default_nettype none
`include "sdac_consts.vh"

// Board select comparator, purely combinational
module sdac_board_decode (
  input  wire [`SDAC_ADDR_W-1:0] wordAddr,
  input  wire [`SDAC_HI_W-1:0]   highSwitchOpen,
  input  wire [`SDAC_LO_W-1:0]   lowSwitchOpen,
  input  wire                    accessSupervisor,
  input  wire                    addrModStrapFitted,
  output wire                    boardHit,
  output wire [`SDAC_CH_W-1:0]   chanIndex
);

  // Open switch expects one, closed expects zero
  wire hiMatch;
  wire loMatch;
  wire amMatch;

  assign hiMatch = (wordAddr[`SDAC_HI_MSB:`SDAC_HI_LSB] == highSwitchOpen);
  assign loMatch = (wordAddr[`SDAC_LO_MSB:`SDAC_LO_LSB] == lowSwitchOpen);

  // Strap absent: supervisory only; fitted: non-privileged only
  assign amMatch = addrModStrapFitted ? ~accessSupervisor : accessSupervisor;

  assign boardHit  = hiMatch & loMatch & amMatch;
  // Consecutive words land on consecutive channels
  assign chanIndex = wordAddr[`SDAC_CH_MSB:`SDAC_CH_LSB];

endmodule // sdac_board_decode
`default_nettype wire

/* File: src/sdac_channel_bank.v */
`timescale 1ns/100ps
`default_nettype none
`include "sdac_consts.vh"

// Two-rank code storage for all channels
module sdac_channel_bank #(
  parameter CH_N = `SDAC_CH_N,
  parameter W    = `SDAC_CODE_W
) (
  input  wire                    sys_clk,
  input  wire                    reset_n,
  input  wire                    wrEn,
  input  wire [`SDAC_CH_W-1:0]   wrChan,
  input  wire [W-1:0]            wrCode,
  input  wire [`SDAC_GROUP_N-1:0] immGroup,
  input  wire                    updateAll,
  input  wire [`SDAC_CH_W-1:0]   rdChan,
  output reg  [W-1:0]            rdCode_q,
  output wire [CH_N*W-1:0]       outCodes
);

  genvar g;
  generate
    for (g = 0; g < CH_N; g = g + 1) begin : gCh
      reg  [W-1:0] firstRank_q;   // Loaded by channel writes
      reg  [W-1:0] secondRank_q;  // Drives the converter
      wire         hitThis;

      // Channel number widened to the genvar's width on purpose
      assign hitThis = wrEn & ({{(32-`SDAC_CH_W){1'b0}}, wrChan} == g);
      assign outCodes[g*W +: W] = secondRank_q;

      // First rank follows every write to this channel
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          firstRank_q <= `SDAC_CODE_RST;
        end else if (hitThis) begin
          firstRank_q <= wrCode;
        end
      end

      // Immediate group bypasses to second rank; else wait for update
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          secondRank_q <= `SDAC_CODE_RST;
        end else if (hitThis && immGroup[g/4]) begin
          secondRank_q <= wrCode;
        end else if (updateAll) begin
          secondRank_q <= firstRank_q;
        end
      end
    end
  endgenerate

  // Registered readback of the live output code
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdCode_q <= `SDAC_CODE_RST;
    end else begin
      rdCode_q <= outCodes[rdChan*W +: W];
    end
  end

endmodule // sdac_channel_bank
`default_nettype wire

/* File: src/sdac_update_control.v */
`timescale 1ns/100ps
`default_nettype none
`include "sdac_consts.vh"

module sdac_update_control #(
  parameter CH_N = `SDAC_CH_N,
  parameter W    = `SDAC_CODE_W
) (
  input  wire                    sys_clk,
  input  wire                    reset_n,
  // Avalon-MM slave, 16-bit words, word address
  input  wire [`SDAC_ADDR_W-1:0] avs_address,
  input  wire                    avs_read,
  input  wire                    avs_write,
  input  wire [`SDAC_DATA_W-1:0] avs_writedata,
  input  wire [1:0]              avs_byteenable,
  output wire [`SDAC_DATA_W-1:0] avs_readdata,
  output wire                    avs_waitrequest,
  // Access privilege of the current cycle
  input  wire                    accessSupervisor,
  // Board straps and switches
  input  wire [`SDAC_HI_W-1:0]   highAddressSwitches,
  input  wire [`SDAC_LO_W-1:0]   lowAddressSwitches,
  input  wire                    addressModifierStrap,
  input  wire [`SDAC_GROUP_N-1:0] updateModeStraps,
  input  wire                    triggerEnableStrap,
  input  wire                    extTrigger,
  // Converter and routing outputs
  output wire [CH_N*W-1:0]       channelCodes,
  output wire                    fieldOutputEngage,
  output wire                    testRouteEnable,
  output wire                    inputTestBusOne,
  output wire                    outputTestBusTwo,
  output wire                    failIndicatorOn,
  output wire [`SDAC_CH_W-1:0]   testSelect,
  output wire                    updatePulse
);

  // Bus handshake state
  reg                    ack_q;      // High in the answering cycle
  wire                   ack_d;
  wire                   reqActive;  // Read or write presented
  wire                   wrAccept;   // Write completes this edge
  reg                    rdHit_q;    // Read was aimed at this board
  wire                   rdHit_d;

  // Decoder results
  wire                   boardHit;
  wire [`SDAC_CH_W-1:0]  chanIndex;

  // Write classification
  wire                   fullWord;   // Both byte lanes enabled
  wire                   ctrlWrite;
  wire                   chanWrite;
  wire [W-1:0]           chanCode;

  // Control register, bits 14..8 of the control word
  reg  [6:0]             ctrl_q;
  reg  [6:0]             ctrl_d;
  reg  [`SDAC_CH_W-1:0]  testSel_q;
  reg  [`SDAC_CH_W-1:0]  testSel_d;

  // Update sources
  wire                   startConvert;
  reg                    trigPrev_q; // Last trigger level seen
  wire                   trigEdge;
  wire                   updateAll;
  reg                    updateSeen_q;

  // Readback
  wire [W-1:0]           rdCode;

  // Address split of the word address (bus bits 15..1):
  //   14..6  compared with the high switches
  //   5..4   compared with the low switches
  //   3..0   channel number
  // With factory switches the board answers at word 0x30,
  // byte address 0xFF0060 in the short I/O space.
  // Board select and channel index
  sdac_board_decode uDecode (
    .wordAddr           (avs_address),
    .highSwitchOpen     (highAddressSwitches),
    .lowSwitchOpen      (lowAddressSwitches),
    .accessSupervisor   (accessSupervisor),
    .addrModStrapFitted (addressModifierStrap),
    .boardHit           (boardHit),
    .chanIndex          (chanIndex)
  );

  // Bus timing, one access:
  //   edge 0  request seen, waitrequest high, answer flag set
  //   edge 1  waitrequest low; write stored, read data taken
  //   edge 2  flag clear since edge 1, ready for the next request
  // A fixed single wait keeps the readback path simple: the
  // channel code is registered during the wait cycle, so the
  // data bus never sees a combinational path through the
  // channel mux. The cost is one extra cycle per access.
  // Misses and dropped writes are answered the same way, so
  // a wrong address or privilege never hangs the host.
  // Every access takes exactly one wait cycle
  assign reqActive       = avs_read | avs_write;
  assign ack_d           = reqActive & ~ack_q;
  assign avs_waitrequest = reqActive & ~ack_q;

  // Answer flag; drops after each completed access so back
  // to back requests each see one wait cycle
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  // Data word layout seen on a write:
  //   bit 15      0 = channel code, 1 = control word
  //   bits 14..12 ignored on channel writes
  //   bits 11..0  offset-binary code on channel writes
  //   bits 14..8  control fields on control writes
  //   bits 7..0   unused on control writes
  // Both kinds share one address per channel; only the top
  // bit tells them apart, so software must keep it right.
  // Partial-lane writes are dropped: the board only
  // understands whole 16-bit words
  assign fullWord = &avs_byteenable;
  assign wrAccept = avs_write & ack_q & boardHit & fullWord;

  // Top data bit steers the word to control or channel
  assign ctrlWrite = wrAccept &  avs_writedata[`SDAC_SEL_BIT];
  assign chanWrite = wrAccept & ~avs_writedata[`SDAC_SEL_BIT];

  // Bits 14..12 of a channel word carry nothing
  assign chanCode = avs_writedata[W-1:0];

  // Control fields held in ctrl_q, bit 0 = word bit 8:
  //   0  field connector engaged
  //   1  start (acts as a pulse, not as a level)
  //   2  test select latch (acts as a pulse)
  //   3  test routing enable
  //   4  test bus one select
  //   5  test bus two select
  //   6  lamp off when high
  // The two pulse bits are kept only so that the stored
  // field mirrors the last control write.
  // Next control value; routing words are plain bit fields,
  // so each documented word selects its path directly
  always @* begin
    ctrl_d = ctrl_q;
    if (ctrlWrite) begin
      ctrl_d = avs_writedata[`SDAC_FAIL_BIT:`SDAC_FIELD_BIT];
    end
  end

  // Control register, cleared at power-up
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `SDAC_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Field positions within the held control bits
  assign fieldOutputEngage = ctrl_q[`SDAC_FIELD_BIT-`SDAC_FIELD_BIT];
  assign testRouteEnable   = ctrl_q[`SDAC_ROUTE_BIT-`SDAC_FIELD_BIT];
  // Test buses only carry a signal while routing is enabled
  assign inputTestBusOne   = ctrl_q[`SDAC_BUS1_BIT-`SDAC_FIELD_BIT] &
                             testRouteEnable;
  assign outputTestBusTwo  = ctrl_q[`SDAC_BUS2_BIT-`SDAC_FIELD_BIT] &
                             testRouteEnable;
  // Lamp is lit while the stored bit is low, so it is lit
  // from reset until software writes the bit high
  assign failIndicatorOn   = ~ctrl_q[`SDAC_FAIL_BIT-`SDAC_FIELD_BIT];

  // Test channel select, loaded from the channel address
  // of a control write carrying bit ten
  always @* begin
    testSel_d = testSel_q;
    if (ctrlWrite && avs_writedata[`SDAC_TSEL_BIT]) begin
      testSel_d = chanIndex;
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      testSel_q <= `SDAC_TSEL_RST;
    end else begin
      testSel_q <= testSel_d;
    end
  end

  assign testSelect = testSel_q;

  // Update sources. Each channel has two ranks: the first
  // takes every channel write, the second drives the
  // converter. Delayed groups only move first to second on
  // a start bit or an honoured trigger edge, so all of them
  // change on one and the same clock edge.
  // The trigger pin is assumed to be already synchronous;
  // a raw board-level pulse needs a synchroniser in front,
  // which would add two cycles of latency to every trigger update.
  // Program-controlled start
  assign startConvert = ctrlWrite & avs_writedata[`SDAC_START_BIT];

  // Trigger input taken as synchronous; rising edge only,
  // so a held-high trigger fires once
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      trigPrev_q <= 1'b0;
    end else begin
      trigPrev_q <= extTrigger;
    end
  end

  // With the strap absent the pin is ignored entirely, so a
  // floating or noisy trigger line cannot move any output.
  // Trigger counts only with its enable strap fitted
  assign trigEdge = extTrigger & ~trigPrev_q & triggerEnableStrap;

  // Either source moves every first rank to second rank
  assign updateAll = startConvert | trigEdge;

  // The flag lets a watcher count updates without decoding
  // the bus; it rises on the update edge itself, with the codes.
  // One-cycle flag after each simultaneous update
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      updateSeen_q <= 1'b0;
    end else begin
      updateSeen_q <= updateAll;
    end
  end

  assign updatePulse = updateSeen_q;

  // Strap mapping: bit k of updateModeStraps covers channels
  // 4k to 4k+3. A fitted strap reads as one and selects the
  // delayed path; the factory state, no straps, is all
  // immediate. Straps are read every cycle, so moving one
  // while running takes effect on the next write.
  // Channel storage; absent strap means immediate group.
  // Immediate channels also take the update, harmlessly,
  // as both ranks already hold the same code.
  sdac_channel_bank #(
    .CH_N (CH_N),
    .W    (W)
  ) uBank (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .wrEn      (chanWrite),
    .wrChan    (chanIndex),
    .wrCode    (chanCode),
    .immGroup  (~updateModeStraps),
    .updateAll (updateAll),
    .rdChan    (chanIndex),
    .rdCode_q  (rdCode),
    .outCodes  (channelCodes)
  );

  // Readback: the host sees the live second-rank code of the
  // addressed channel in the low twelve bits, upper bits zero.
  // A read that misses the board returns all zeros. Control
  // fields cannot be read back; the host keeps its own copy.
  // The hit flag is registered with the code so both
  // change together at the wait-cycle edge.
  // Remember whether the read was for this board; the code
  // itself is sampled by the bank during the wait cycle
  assign rdHit_d = avs_read & ~ack_q & boardHit;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdHit_q <= 1'b0;
    end else begin
      rdHit_q <= rdHit_d;
    end
  end

  // Reads return the live output code; misses read zero
  assign avs_readdata = rdHit_q ?
                        {{(`SDAC_DATA_W-W){1'b0}}, rdCode} :
                        {`SDAC_DATA_W{1'b0}};

endmodule // sdac_update_control
`default_nettype wire

/* File: tb/sdac_update_control_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
// Watches the control block from its ports only
module sdac_update_monitor #(
  parameter CH_N = 16,
  parameter W    = 12
) (
  input wire          sys_clk,
  input wire          reset_n,
  input wire [14:0]   avs_address,
  input wire          avs_read,
  input wire          avs_write,
  input wire [15:0]   avs_writedata,
  input wire [1:0]    avs_byteenable,
  input wire [15:0]   avs_readdata,
  input wire          avs_waitrequest,
  input wire          accessSupervisor,
  input wire [8:0]    highAddressSwitches,
  input wire [1:0]    lowAddressSwitches,
  input wire          addressModifierStrap,
  input wire [3:0]    updateModeStraps,
  input wire          triggerEnableStrap,
  input wire          extTrigger,
  input wire [CH_N*W-1:0] channelCodes,
  input wire          fieldOutputEngage,
  input wire          testRouteEnable,
  input wire          inputTestBusOne,
  input wire          outputTestBusTwo,
  input wire          failIndicatorOn,
  input wire [3:0]    testSelect,
  input wire          updatePulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic trigPrev_q; // Trigger level at the previous edge
  // Edge detect reference for the trigger
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) trigPrev_q <= 1'b0;
    else trigPrev_q <= extTrigger;
  end
  wire addrHit = avs_address[14:6] == highAddressSwitches && avs_address[5:4] == lowAddressSwitches
                 && accessSupervisor != addressModifierStrap; // Board selected
  wire done = avs_write && !avs_waitrequest && addrHit && &avs_byteenable; // Write lands
  wire ctl = done && avs_writedata[15];  // Control word write
  wire chw = done && !avs_writedata[15]; // Channel code write
  wire trg = triggerEnableStrap && extTrigger && !trigPrev_q; // Honoured trigger edge
  wire imm = !updateModeStraps[avs_address[3:2]]; // Addressed group is immediate
  chk_lamp_field: assert property (ctl |=> failIndicatorOn == !$past(avs_writedata[14])
    && fieldOutputEngage == $past(avs_writedata[8])) else $error("lamp or field bit wrong");
  chk_test_route: assert property (ctl |=> testRouteEnable == $past(avs_writedata[11])
    && inputTestBusOne == ($past(avs_writedata[12]) && $past(avs_writedata[11]))
    && outputTestBusTwo == ($past(avs_writedata[13]) && $past(avs_writedata[11]))) else $error("route wrong");
  chk_start_pulse: assert property (ctl && avs_writedata[9] |=> updatePulse)
    else $error("no pulse after start");
  chk_trig_pulse: assert property (trg |=> updatePulse) else $error("no pulse after trigger");
  chk_pulse_cause: assert property (updatePulse |-> $past(trg) || $past(ctl && avs_writedata[9]))
    else $error("pulse without cause");
  chk_imm_write: assert property (chw && imm |=>
    channelCodes[$past(avs_address[3:0])*W +: W] == $past(avs_writedata[W-1:0])) else $error("code not out");
  chk_dly_hold: assert property (chw && !imm && !trg |=> $stable(channelCodes))
    else $error("delayed code leaked");
  chk_tsel_latch: assert property (ctl && avs_writedata[10] |=> testSelect == $past(avs_address[3:0]))
    else $error("test select wrong");
  chk_miss_read: assert property (avs_read && !avs_waitrequest && !addrHit |-> avs_readdata == 16'h0000)
    else $error("miss read not zero");
  cover property (ctl && avs_writedata[9]);
  cover property (trg);
  cover property (chw && !imm);
endmodule // sdac_update_monitor
bind sdac_update_control sdac_update_monitor #(.CH_N(CH_N), .W(W)) mon (
  .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .accessSupervisor(accessSupervisor),
  .highAddressSwitches(highAddressSwitches), .lowAddressSwitches(lowAddressSwitches),
  .addressModifierStrap(addressModifierStrap), .updateModeStraps(updateModeStraps),
  .triggerEnableStrap(triggerEnableStrap), .extTrigger(extTrigger), .channelCodes(channelCodes),
  .fieldOutputEngage(fieldOutputEngage), .testRouteEnable(testRouteEnable),
  .inputTestBusOne(inputTestBusOne), .outputTestBusTwo(outputTestBusTwo),
  .failIndicatorOn(failIndicatorOn), .testSelect(testSelect), .updatePulse(updatePulse));
`default_nettype wire

/* File: tb/sdac_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Bus processor issuing word accesses
module sdac_host_model (
  input wire logic         sys_clk,
  input wire logic         avs_waitrequest,
  input wire logic [15:0]  avs_readdata,
  output logic [14:0]      avs_address = 15'h7FFF,
  output logic             avs_read = 1'b0,
  output logic             avs_write = 1'b0,
  output logic [15:0]      avs_writedata = 16'hFFFF,
  output logic [1:0]       avs_byteenable = 2'h3
);
  logic       tmo = 1'b0; // Last wait ran out
  logic [1:0] be = 2'h3;  // Lanes for the next access
  // One access; held until the slave stops waiting or 16 edges pass
  task automatic xfer(input logic w, input logic [14:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge sys_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d; // Control words carry a set top bit
    avs_byteenable <= be;
    q = 16'h0000;
    tmo = 1'b1;
    for (int i = 0; i < 16 && tmo; i++) begin
      @(posedge sys_clk);
      if (!avs_waitrequest) begin
        tmo = 1'b0;
        q = avs_readdata;
      end
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    avs_address <= ~a; // Released lines show no stale value
    avs_writedata <= ~d;
  endtask
endmodule // sdac_host_model
`default_nettype wire

/* File: tb/test_sdac_update_control.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sdac_consts.vh"
module test_sdac_update_control;
  logic sys_clk = 1'b0, reset_n = 1'b0; // Clock and reset
  logic accessSupervisor = 1'b1, addressModifierStrap = 1'b0, triggerEnableStrap = 1'b0, extTrigger = 1'b0;
  logic [8:0] highAddressSwitches = `SDAC_HI_SW_FACTORY; // Factory base
  logic [1:0] lowAddressSwitches = `SDAC_LO_SW_FACTORY;
  logic [3:0] updateModeStraps = 4'h0; // Factory immediate
  wire [14:0] avs_address;
  wire [15:0] avs_writedata, avs_readdata;
  wire [1:0] avs_byteenable;
  wire avs_read, avs_write, avs_waitrequest, updatePulse;
  wire [191:0] channelCodes;
  wire [3:0] testSelect;
  wire fieldOutputEngage, testRouteEnable, inputTestBusOne, outputTestBusTwo, failIndicatorOn;
  int nErrors = 0, nCompared = 0; // Tallies
  localparam logic [14:0] BASE = 15'h0030; // Word address of byte FF0060
  logic [15:0] q;
  always #2 sys_clk = ~sys_clk;
  sdac_update_control DUT (.sys_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .accessSupervisor, .highAddressSwitches,
    .lowAddressSwitches, .addressModifierStrap, .updateModeStraps, .triggerEnableStrap, .extTrigger,
    .channelCodes, .fieldOutputEngage, .testRouteEnable, .inputTestBusOne, .outputTestBusTwo,
    .failIndicatorOn, .testSelect, .updatePulse);
  sdac_host_model host (.sys_clk, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable);
  task automatic results;
    $display("Compared %0d, errors %0d", nCompared, nErrors);
    if (nErrors == 0 && nCompared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [191:0] seen, input logic [191:0] exp);
    nCompared++;
    if (seen !== exp) begin
      nErrors++;
      $display("BAD %0t saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [15:0] d);
    host.xfer(1'b1, a, d, q);
    if (host.tmo) begin nErrors++; results; end
    @(negedge sys_clk); // Stored values have landed
  endtask
  task automatic rd(input logic [14:0] a);
    host.xfer(1'b0, a, 16'h0000, q);
    if (host.tmo) begin nErrors++; results; end
  endtask
  function automatic logic [4:0] outs(input logic [15:0] w); // Routing outputs a word should give
    return {w[8], w[11], w[12] & w[11], w[13] & w[11], !w[14]};
  endfunction
  task automatic ctl(input logic [15:0] w);
    wr(BASE, w);
    chk(updatePulse, w[9]);
    @(negedge sys_clk);
    chk({fieldOutputEngage, testRouteEnable, inputTestBusOne, outputTestBusTwo, failIndicatorOn}, outs(w));
  endtask
  // Immediate words, consecutive channels, code masking and readback
  task automatic t_immediate;
    logic [15:0] w [4] = '{`SDAC_CW_IMM_FIELD, `SDAC_CW_IMM_BUS2, `SDAC_CW_IMM_BUS1, `SDAC_CW_IMM_B2FLD};
    for (int k = 0; k < 4; k++) ctl(w[k]);
    for (int n = 0; n < 16; n++) begin
      wr(BASE + 15'(n), {4'h7, 4'(n), 8'hA5});
      chk(channelCodes[n*12 +: 12], {4'(n), 8'hA5});
    end
    for (int n = 0; n < 16; n++) begin
      rd(BASE + 15'(n));
      chk(q, {8'h00, 4'(n), 8'hA5});
    end
  endtask
  // Mixed straps, start bit moves every delayed group at once
  task automatic t_delayed;
    logic [15:0] w [4] = '{`SDAC_CW_DLY_FIELD, `SDAC_CW_DLY_BUS2, `SDAC_CW_DLY_BUS1, `SDAC_CW_DLY_B2FLD};
    @(posedge sys_clk);
    updateModeStraps <= 4'b0101;
    for (int n = 0; n < 16; n++) wr(BASE + 15'(n), {4'h0, ~4'(n), 8'h3C});
    for (int n = 0; n < 16; n++)
      chk(channelCodes[n*12 +: 12], (n / 4) % 2 == 0 ? {4'(n), 8'hA5} : {~4'(n), 8'h3C});
    for (int k = 0; k < 4; k++) ctl(w[k]);
    for (int n = 0; n < 16; n++) chk(channelCodes[n*12 +: 12], {~4'(n), 8'h3C});
  endtask
  task automatic pulse(input logic exp);
    @(posedge sys_clk) extTrigger <= 1'b1;
    @(posedge sys_clk) extTrigger <= 1'b0;
    @(negedge sys_clk) chk(updatePulse, exp);
    repeat (2) @(posedge sys_clk);
  endtask
  // Trigger ignored without its strap, honoured with it
  task automatic t_trigger;
    @(posedge sys_clk);
    updateModeStraps <= 4'hF;
    wr(BASE + 15'h3, 16'h0123);
    pulse(1'b0);
    chk(channelCodes[36 +: 12], {~4'h3, 8'h3C});
    triggerEnableStrap <= 1'b1;
    pulse(1'b1);
    chk(channelCodes[36 +: 12], 12'h123);
  endtask
  // Privilege, lanes, switches and test select
  task automatic t_decode;
    updateModeStraps <= 4'h0;
    accessSupervisor <= 1'b0;
    wr(BASE, 16'h0111);
    rd(BASE);
    chk(q, 16'h0000);
    addressModifierStrap <= 1'b1;
    wr(BASE, 16'h0222);
    chk(channelCodes[11:0], 12'h222);
    host.be <= 2'h1;
    wr(BASE, 16'h0333);
    host.be <= 2'h3;
    wr(15'h0020, 16'h0444);
    chk(channelCodes[11:0], 12'h222);
    @(posedge sys_clk);
    highAddressSwitches <= 9'h001;
    wr(15'h0070, 16'h0555);
    chk(channelCodes[11:0], 12'h555);
    wr(15'h0079, `SDAC_CW_IMM_BUS1);
    chk(testSelect, 4'h9);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    chk(channelCodes, 192'h0);
    chk({fieldOutputEngage, testRouteEnable, inputTestBusOne, outputTestBusTwo, failIndicatorOn, testSelect,
         updatePulse}, 11'h020);
    t_immediate;
    t_delayed;
    t_trigger;
    t_decode;
    results;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    nErrors++;
    results;
  end
endmodule // test_sdac_update_control
`default_nettype wire
